// ---- rtl/ccr_pkg.sv ----
// shared constants, field layouts and carrier types of the clock conditioner reconfiguration block
package ccr_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned LOCK_NS = 1000;
	// least time, rounded up to whole cycles
	localparam int unsigned LOCK_CYC = (LOCK_NS * CLK_MHZ + 999) / 1000;
	localparam logic [6:0] LOCK_LAST = 7'(LOCK_CYC - 1);

	////////////////////////////////////////////////////////////////////////////
	// reconfiguration port layout
	localparam int unsigned CTL_WR = 10;
	localparam int unsigned CTL_RD = 9;
	localparam int unsigned ADDR_W = 9;
	localparam int unsigned DATA_W = 33;

	// register word offsets
	localparam logic [8:0] OFF_DLL = 9'h000;
	localparam logic [8:0] OFF_PLL = 9'h001;
	localparam logic [8:0] OFF_STAT = 9'h002;
	localparam logic [8:0] OFF_ISTAT = 9'h003;
	localparam logic [8:0] OFF_IMASK = 9'h004;

	////////////////////////////////////////////////////////////////////////////
	// field codes
	localparam logic [1:0] DIV_1 = 2'h0;
	localparam logic [1:0] DIV_2 = 2'h1;
	localparam logic [1:0] DIV_4 = 2'h2;
	localparam logic [1:0] DIV_BAD = 2'h3;

	typedef enum logic [1:0] {
		JIT_LOW = 2'h0,
		JIT_MED_LOW = 2'h1,
		JIT_MED_HIGH = 2'h2,
		JIT_HIGH = 2'h3
	} ccr_jitter_type;

	// interrupt status bit positions
	localparam int unsigned IRQ_LOCK = 0;
	localparam int unsigned IRQ_UNLOCK = 1;
	localparam int unsigned IRQ_REFUSE = 2;
	localparam int unsigned IRQ_GLITCH = 3;
	localparam int unsigned IRQ_W = 4;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [4:0] sec_phase;
		logic sec_duty50;
		logic sec_dedicated;
		logic injection;
		logic cascade;
		logic ref_out3;
		logic pd_soft;
		logic pd_port_en;
		logic fastio_net;
		ccr_jitter_type jitter;
		logic [1:0] sec_div;
	} ccr_dll_cfg_type;

	typedef struct packed {
		logic post_vco;
		logic [3:0] out_en;
		logic [7:0] out_div;
		logic [1:0] phase;
	} ccr_pll_cfg_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [8:0] addr;
		logic [32:0] data;
	} ccr_req_type;

	// power-up values standing in for the nonvolatile configuration bits
	localparam ccr_dll_cfg_type NV_DLL = 17'h00000;
	localparam ccr_pll_cfg_type NV_PLL = 15'h3c04;

endpackage

// ---- rtl/ccr_port_decode.sv ----
// splits the live reconfiguration port control word into a request
`timescale 1ns/1ps
`default_nettype none
module ccr_port_decode (
	input wire logic port_en_in,
	input wire logic [10:0] ctrl_in,
	input wire logic [32:0] wdata_in,
	output ccr_pkg::ccr_req_type req_out
);
	// a control word with both strobes is taken as a write only
	always_comb begin
		req_out.wr = port_en_in & ctrl_in[ccr_pkg::CTL_WR];
		req_out.rd = port_en_in & ctrl_in[ccr_pkg::CTL_RD] & ~ctrl_in[ccr_pkg::CTL_WR];
		req_out.addr = ctrl_in[8:0];
		req_out.data = wdata_in;
	end
endmodule
`default_nettype wire

// ---- rtl/ccr_sec_div.sv ----
// secondary output divider: toggles on every 1st, 2nd or 4th reference edge
`timescale 1ns/1ps
`default_nettype none
module ccr_sec_div (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic run_in,
	input wire logic ref_in,
	input wire logic [1:0] div_in,
	output logic clk_q_out
);
	logic ref_q;
	logic primed_q;
	logic [1:0] cnt_q;
	logic [1:0] last;
	logic edge_seen;

	// first sample after reset only primes, so a reference that is already high is not taken as an edge
	assign edge_seen = primed_q & (ref_in ^ ref_q);
	assign last = (div_in == ccr_pkg::DIV_4) ? 2'h3 : (div_in == ccr_pkg::DIV_2) ? 2'h1 : 2'h0;

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ref_q <= 1'b0;
			primed_q <= 1'b0;
		end else if (ce_in) begin
			ref_q <= ref_in;
			primed_q <= 1'b1;
		end
	end

	// count restarts at each toggle, so a new ratio takes hold without a runt pulse
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cnt_q <= 2'h0;
			clk_q_out <= 1'b0;
		end else if (ce_in) begin
			if (!run_in) begin
				cnt_q <= 2'h0;
				clk_q_out <= 1'b0;
			end else if (edge_seen) begin
				if (cnt_q >= last) begin
					cnt_q <= 2'h0;
					clk_q_out <= ~clk_q_out;
				end else begin
					cnt_q <= cnt_q + 2'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/ccr_top.sv ----
// clock conditioner: delay loop secondary output, synthesizer sleep and live reconfiguration registers
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ccr_top (
	input wire logic sys_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic reconfig_en_in,
	input wire logic [10:0] reconfig_ctrl_in,
	input wire logic [32:0] reconfig_wdata_in,
	output logic [32:0] reconfig_rdata_out,
	output logic reconfig_irq_out,
	input wire logic synth_sleep_n_in,
	input wire logic dll_pd_port_in,
	input wire logic ext_ref_in,
	input wire logic pll_out2_in,
	input wire logic pll_out3_in,
	output logic sec_clk_global_out,
	output logic sec_clk_fastio_out,
	output logic [1:0] jitter_range_out,
	output logic [4:0] sec_phase_out,
	output logic sec_duty50_out,
	output logic sec_dedicated_out,
	output logic dll_pd_out,
	output logic pll_rst_out,
	output logic pll_locked_out,
	output logic [3:0] out_gate_out,
	output logic [7:0] pll_div_out,
	output logic [1:0] pll_phase_out
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	// settings that injection removal mode does not offer are forced off
	function automatic ccr_pkg::ccr_dll_cfg_type eff_dll(input ccr_pkg::ccr_dll_cfg_type c);
		ccr_pkg::ccr_dll_cfg_type e;
		e = c;
		if (c.injection) begin
			e.sec_phase = 5'h00;
			e.sec_duty50 = 1'b0;
			e.sec_dedicated = 1'b0;
		end
		return e;
	endfunction

	function automatic logic hit(input ccr_pkg::ccr_req_type r, input logic [8:0] off);
		return r.addr == off;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// declarations
	ccr_pkg::ccr_req_type req;
	ccr_pkg::ccr_dll_cfg_type dll_q;
	ccr_pkg::ccr_dll_cfg_type dll_wr;
	ccr_pkg::ccr_dll_cfg_type dll_eff;
	ccr_pkg::ccr_pll_cfg_type pll_q;
	ccr_pkg::ccr_pll_cfg_type pll_wr;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_stat_d;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_ev;
	logic irq_pend;
	logic [6:0] lock_cnt_q;
	logic pll_wr_hit;
	logic core_change;
	logic out_change;
	logic pll_refuse;
	logic pll_glitch;
	logic dll_pd_eff;
	logic dll_ref;
	logic sec_clk;
	logic [32:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////
	// live reconfiguration port
	// the port is reached only through these pins; nothing else taps it
	ccr_port_decode u_decode (
		.port_en_in(reconfig_en_in),
		.ctrl_in(reconfig_ctrl_in),
		.wdata_in(reconfig_wdata_in),
		.req_out(req)
	);

	assign dll_eff = eff_dll(dll_q);
	assign dll_wr = ccr_pkg::ccr_dll_cfg_type'(req.data[16:0]);
	assign pll_wr = ccr_pkg::ccr_pll_cfg_type'(req.data[14:0]);

	////////////////////////////////////////////////////////////////////////////
	// delay loop configuration
	// registers come up at the nonvolatile values, reset on the port's own reset
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			dll_q <= ccr_pkg::NV_DLL;
		end else if (ce_in && req.wr && hit(req, ccr_pkg::OFF_DLL)) begin
			dll_q <= dll_wr;
			// a reserved ratio leaves the old one in place
			if (dll_wr.sec_div == ccr_pkg::DIV_BAD) begin
				dll_q.sec_div <= dll_q.sec_div;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// synthesizer configuration
	assign pll_wr_hit = ce_in && req.wr && hit(req, ccr_pkg::OFF_PLL);
	assign core_change = pll_wr.post_vco != pll_q.post_vco;
	assign out_change = (pll_wr.out_div != pll_q.out_div) || (pll_wr.phase != pll_q.phase);
	// awake: loop parameters refused outright; output settings only in post-VCO mode
	assign pll_refuse = pll_wr_hit && synth_sleep_n_in && (core_change || (out_change && !pll_q.post_vco));
	// output change with a gate still open would glitch; applied but flagged
	assign pll_glitch = pll_wr_hit && synth_sleep_n_in && !core_change && out_change && pll_q.post_vco &&
		(|(pll_q.out_en & pll_wr.out_en));

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pll_q <= ccr_pkg::NV_PLL;
		end else if (pll_wr_hit) begin
			// gates may be moved at any time
			pll_q.out_en <= pll_wr.out_en;
			if (!pll_refuse) begin
				pll_q.post_vco <= pll_wr.post_vco;
				pll_q.out_div <= pll_wr.out_div;
				pll_q.phase <= pll_wr.phase;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep and lock
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lock_cnt_q <= 7'h00;
			pll_locked_out <= 1'b0;
			pll_rst_out <= 1'b1;
		end else if (ce_in) begin
			pll_rst_out <= !synth_sleep_n_in;
			if (!synth_sleep_n_in) begin
				lock_cnt_q <= 7'h00;
				pll_locked_out <= 1'b0;
			end else if (!pll_locked_out) begin
				if (lock_cnt_q == ccr_pkg::LOCK_LAST) begin
					pll_locked_out <= 1'b1;
				end else begin
					lock_cnt_q <= lock_cnt_q + 7'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// delay loop reference, power-down and secondary output
	assign dll_pd_eff = dll_q.pd_port_en ? dll_pd_port_in : dll_q.pd_soft;
	// cascade takes synthesizer output two or three instead of the pin reference
	assign dll_ref = dll_q.cascade ? (dll_q.ref_out3 ? pll_out3_in : pll_out2_in) : ext_ref_in;

	ccr_sec_div u_sec_div (
		.sys_clk_in(sys_clk_in),
		.nrst_in(nrst_in),
		.ce_in(ce_in),
		.run_in(!dll_pd_eff),
		.ref_in(dll_ref),
		.div_in(dll_q.sec_div),
		.clk_q_out(sec_clk)
	);

	// outputs re-registered so every pin starts at a flip-flop
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sec_clk_global_out <= 1'b0;
			sec_clk_fastio_out <= 1'b0;
			jitter_range_out <= 2'h0;
			sec_phase_out <= 5'h00;
			sec_duty50_out <= 1'b0;
			sec_dedicated_out <= 1'b0;
			dll_pd_out <= 1'b0;
			out_gate_out <= 4'h0;
			pll_div_out <= 8'h00;
			pll_phase_out <= 2'h0;
		end else if (ce_in) begin
			// the unused net is held low, never driven with a copy
			sec_clk_global_out <= sec_clk && !dll_eff.fastio_net;
			sec_clk_fastio_out <= sec_clk && dll_eff.fastio_net;
			jitter_range_out <= dll_eff.jitter;
			sec_phase_out <= dll_eff.sec_phase;
			sec_duty50_out <= dll_eff.sec_duty50;
			sec_dedicated_out <= dll_eff.sec_dedicated;
			dll_pd_out <= dll_pd_eff;
			// gates close while the synthesizer is held in reset
			out_gate_out <= synth_sleep_n_in ? pll_q.out_en : 4'h0;
			pll_div_out <= pll_q.out_div;
			pll_phase_out <= pll_q.phase;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts: sticky, write one to clear, a new event beats the clear
	always_comb begin
		irq_ev = 4'h0;
		irq_ev[ccr_pkg::IRQ_LOCK] = ce_in && synth_sleep_n_in && !pll_locked_out &&
			lock_cnt_q == ccr_pkg::LOCK_LAST;
		irq_ev[ccr_pkg::IRQ_UNLOCK] = ce_in && pll_locked_out && !synth_sleep_n_in;
		irq_ev[ccr_pkg::IRQ_REFUSE] = pll_refuse;
		irq_ev[ccr_pkg::IRQ_GLITCH] = pll_glitch;
		irq_stat_d = irq_stat_q;
		if (ce_in && req.wr && hit(req, ccr_pkg::OFF_ISTAT)) begin
			irq_stat_d = irq_stat_d & ~req.data[3:0];
		end
		irq_stat_d = irq_stat_d | irq_ev;
	end

	assign irq_pend = |(irq_stat_q & irq_mask_q);

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_stat_q <= 4'h0;
			irq_mask_q <= 4'h0;
			reconfig_irq_out <= 1'b0;
		end else if (ce_in) begin
			irq_stat_q <= irq_stat_d;
			if (req.wr && hit(req, ccr_pkg::OFF_IMASK)) begin
				irq_mask_q <= req.data[3:0];
			end
			reconfig_irq_out <= irq_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path: data stand only in the cycle after the read strobe
	always_comb begin
		rd_mux = 33'h000000000;
		unique case (req.addr)
			ccr_pkg::OFF_DLL: rd_mux = 33'(dll_q);
			ccr_pkg::OFF_PLL: rd_mux = 33'(pll_q);
			ccr_pkg::OFF_STAT: rd_mux = {25'h0000000, pll_rst_out, dll_pd_out, dll_eff.sec_dedicated,
				dll_eff.sec_duty50, sec_clk, dll_ref, !synth_sleep_n_in, pll_locked_out};
			ccr_pkg::OFF_ISTAT: rd_mux = 33'(irq_stat_q);
			ccr_pkg::OFF_IMASK: rd_mux = 33'(irq_mask_q);
			default: rd_mux = 33'h000000000;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			reconfig_rdata_out <= 33'h000000000;
		end else if (ce_in) begin
			reconfig_rdata_out <= req.rd ? rd_mux : 33'h000000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	a_sleep_holds_reset: assert property (ce_in && !synth_sleep_n_in |=> pll_rst_out && !pll_locked_out)
		else $error("synthesizer not held in reset during sleep");
	a_lock_after_count: assert property ($rose(pll_locked_out) |-> $past(lock_cnt_q) == ccr_pkg::LOCK_LAST)
		else $error("lock came before the lock count ran out");
	a_inj_no_phase: assert property (ce_in && dll_q.injection |=> sec_phase_out == 5'h00 && !sec_duty50_out)
		else $error("phase or duty regulation active in injection mode");
	a_inj_no_route: assert property (ce_in && dll_q.injection |=> !sec_dedicated_out)
		else $error("dedicated route used in injection mode");
	a_net_one_only: assert property (!(sec_clk_global_out && sec_clk_fastio_out))
		else $error("secondary clock on both nets");
	a_div_legal: assert property (dll_q.sec_div != ccr_pkg::DIV_BAD)
		else $error("reserved secondary divide ratio stored");
	a_rdata_slot: assert property (ce_in && !req.rd |=> reconfig_rdata_out == 33'h000000000)
		else $error("read data outside its slot");
	a_refuse_awake: assert property (pll_wr_hit && synth_sleep_n_in && core_change |=>
		pll_q.post_vco == $past(pll_q.post_vco) && irq_stat_q[ccr_pkg::IRQ_REFUSE])
		else $error("loop parameter changed while awake");
	a_pd_port_follow: assert property (ce_in && dll_q.pd_port_en |=> dll_pd_out == $past(dll_pd_port_in))
		else $error("power-down port not followed");
	a_irq_level: assert property (ce_in |=> reconfig_irq_out == $past(irq_pend))
		else $error("interrupt output does not track masked status");

	c_lock: cover property ($rose(pll_locked_out));
	c_refuse: cover property (pll_refuse);
	c_glitch: cover property (pll_glitch);
	c_inj_div4: cover property (dll_q.injection && dll_q.sec_div == ccr_pkg::DIV_4 && $rose(sec_clk));

endmodule
`default_nettype wire

// ---- tb/ccr_ref_model.sv ----
// far-side reference sources: fabric reference pin and two synthesizer outputs
`timescale 1ns/1ps
`default_nettype none
module ccr_ref_model (
	input wire logic sys_clk_in,
	input wire logic slow_in,
	output logic ext_ref_out,
	output logic out2_out,
	output logic out3_out
);
	int cnt_q;
	initial begin
		cnt_q = 0;
		ext_ref_out = 1'b0;
		out2_out = 1'b0;
		out3_out = 1'b0;
	end
	// levels move only just after an edge, so every half period is whole cycles
	always @(posedge sys_clk_in) begin
		cnt_q <= cnt_q + 1;
		if (cnt_q % (slow_in ? 6 : 3) == 0) begin
			ext_ref_out <= !ext_ref_out;
		end
		if (cnt_q % 2 == 0) begin
			out2_out <= !out2_out;
		end
		if (cnt_q % 5 == 0) begin
			out3_out <= !out3_out;
		end
	end
endmodule
`default_nettype wire

// ---- tb/ccr_tb.sv ----
// self-checking bench of the clock conditioner reconfiguration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module testbench;
	typedef struct {
		string nm;
		logic [32:0] v;
	} ccr_note_type;
	logic sys_clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1, en = 1'b1, sleep_n = 1'b1, pd_port = 1'b0, slow = 1'b0;
	logic [10:0] ctrl = 11'h000;
	logic [32:0] wdata = 33'h0, rdata, v;
	logic irq, ext_ref, out2, out3, sc_glob, sc_fast, duty, ded, pd_out, prst, locked, rd_seen = 1'b0;
	logic [1:0] jit, pph;
	logic [4:0] phase;
	logic [3:0] gate;
	logic [7:0] pdiv;
	logic [31:0] rng = 32'h17b57a42;
	int error_cnt = 0, check_count = 0;
	ccr_note_type notes[$];

	always #5 sys_clk_in = !sys_clk_in;

	ccr_top uut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .reconfig_en_in(en),
		.reconfig_ctrl_in(ctrl), .reconfig_wdata_in(wdata), .reconfig_rdata_out(rdata),
		.reconfig_irq_out(irq), .synth_sleep_n_in(sleep_n), .dll_pd_port_in(pd_port),
		.ext_ref_in(ext_ref), .pll_out2_in(out2), .pll_out3_in(out3), .sec_clk_global_out(sc_glob),
		.sec_clk_fastio_out(sc_fast), .jitter_range_out(jit), .sec_phase_out(phase), .sec_duty50_out(duty),
		.sec_dedicated_out(ded), .dll_pd_out(pd_out), .pll_rst_out(prst), .pll_locked_out(locked),
		.out_gate_out(gate), .pll_div_out(pdiv), .pll_phase_out(pph));
	ccr_ref_model far (.sys_clk_in(sys_clk_in), .slow_in(slow), .ext_ref_out(ext_ref), .out2_out(out2),
		.out3_out(out3));

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	// flags are duty, dedicated, injection, cascade, out3, soft pd, pd port, fast net
	function automatic logic [32:0] dll(input logic [4:0] ph, input logic [7:0] f, input logic [1:0] jt,
		input logic [1:0] dv);
		return {16'h0, ph, f, jt, dv};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic wr(input logic [8:0] a, input logic [32:0] d);
		@(posedge sys_clk_in);
		ctrl <= {2'h2, a};
		wdata <= d;
		@(posedge sys_clk_in);
		ctrl <= 11'h000;
		wdata <= 33'(xs());
	endtask
	task automatic rd(input logic [8:0] a, input logic [32:0] ex, input string nm);
		@(posedge sys_clk_in);
		ctrl <= {2'h1, a};
		notes.push_back('{nm, ex});
		@(posedge sys_clk_in);
		ctrl <= 11'h000;
	endtask
	// spacing of secondary clock changes, which the divider fixes exactly
	task automatic gap(input logic fio, input int ex, input string nm);
		int n;
		logic s;
		tick(30);
		for (int p = 0; p < 2; p++) begin
			s = fio ? sc_fast : sc_glob;
			n = 0;
			while ((fio ? sc_fast : sc_glob) === s && n < 100) begin
				@(posedge sys_clk_in);
				n++;
			end
		end
		`CHK(nm, ex, n)
		`CHK("idle net", 1'b0, fio ? sc_glob : sc_fast)
	endtask
	task automatic give_verdict();
		// a read whose data never came back is a mismatch too
		if (notes.size() != 0) begin
			error_cnt++;
			$display("BAD pending reads exp 0 got %0d", notes.size());
		end
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	always @(posedge sys_clk_in) begin
		if (rd_seen) begin
			if (notes.size() == 0) begin
				error_cnt++;
				$display("BAD read data exp none got %h", rdata);
			end else begin
				`CHK(notes[0].nm, notes[0].v, rdata)
				void'(notes.pop_front());
			end
		end
		rd_seen <= ce_in & en & ctrl[9] & !ctrl[10];
	end

	initial begin
		tick(5000);
		error_cnt++;
		$display("BAD watchdog exp done got timeout");
		give_verdict();
	end

	initial begin
		tick(8);
		nrst_in <= 1'b1;
		tick(3);
		`CHK("nv gates", 4'hf, gate)
		`CHK("nv div", 8'h01, pdiv)
		rd(ccr_pkg::OFF_DLL, 33'h0, "dll nv");
		rd(ccr_pkg::OFF_PLL, 33'h3c04, "pll nv");
		wr(9'h1ff, 33'h1_ffff_ffff);
		rd(9'h1ff, 33'h0, "unmapped");
		rd(ccr_pkg::OFF_IMASK, 33'h0, "mask nv");
		for (int j = 0; j < 4; j++) begin
			v = dll(5'(xs()), {2'h3, 5'h0, 1'(j)}, 2'(j), ccr_pkg::DIV_2);
			wr(ccr_pkg::OFF_DLL, v);
			rd(ccr_pkg::OFF_DLL, v, "dll back");
			tick(1);
			`CHK("jitter", 2'(j), jit)
			`CHK("phase", v[16:12], phase)
			`CHK("duty", 1'b1, duty)
			`CHK("dedicated", 1'b1, ded)
		end
		wr(ccr_pkg::OFF_DLL, dll(5'h1f, 8'he0, ccr_pkg::JIT_HIGH, ccr_pkg::DIV_1));
		tick(3);
		`CHK("inj phase", 5'h0, phase)
		`CHK("inj duty", 1'b0, duty)
		`CHK("inj route", 1'b0, ded)
		for (int s = 0; s < 3; s++) begin
			for (int k = 0; k < 3; k++) begin
				v = dll(5'h0, {3'h1, 1'(s != 0), 1'(s == 2), 2'h0, 1'(k == 1)}, ccr_pkg::JIT_LOW,
					k == 0 ? ccr_pkg::DIV_1 : k == 1 ? ccr_pkg::DIV_2 : ccr_pkg::DIV_4);
				wr(ccr_pkg::OFF_DLL, v);
				gap(1'(k == 1), (1 << k) * (s == 0 ? 3 : s == 1 ? 2 : 5), "sec gap");
			end
		end
		wr(ccr_pkg::OFF_DLL, {v[32:2], ccr_pkg::DIV_BAD});
		gap(1'b0, 20, "reserved div");
		wr(ccr_pkg::OFF_DLL, dll(5'h0, 8'h20, ccr_pkg::JIT_LOW, ccr_pkg::DIV_2));
		slow <= 1'b1;
		gap(1'b0, 12, "slow ref");
		pd_port <= 1'b1;
		tick(3);
		`CHK("pd port off", 1'b0, pd_out)
		wr(ccr_pkg::OFF_DLL, dll(5'h0, 8'h22, ccr_pkg::JIT_LOW, ccr_pkg::DIV_2));
		tick(20);
		`CHK("pd port", 1'b1, pd_out)
		`CHK("stopped", 2'h0, {sc_glob, sc_fast})
		pd_port <= 1'b0;
		wr(ccr_pkg::OFF_DLL, dll(5'h0, 8'h04, ccr_pkg::JIT_LOW, ccr_pkg::DIV_2));
		tick(3);
		`CHK("pd soft", 1'b1, pd_out)
		wr(ccr_pkg::OFF_ISTAT, 33'hf);
		sleep_n <= 1'b0;
		tick(2);
		`CHK("sleep rst", 1'b1, prst)
		`CHK("sleep lock", 1'b0, locked)
		`CHK("sleep gates", 4'h0, gate)
		@(posedge sys_clk_in);
		ctrl <= {2'h1, ccr_pkg::OFF_STAT};
		@(posedge sys_clk_in);
		ctrl <= 11'h000;
		// reference level is the one the design samples at this same edge
		notes.push_back('{"status", {25'h0, 2'h3, 3'h0, ext_ref, 2'h2}});
		v = {18'h0, 1'h1, 4'hf, 8'h07, 2'h2};
		wr(ccr_pkg::OFF_PLL, v);
		rd(ccr_pkg::OFF_PLL, v, "pll asleep");
		tick(2);
		`CHK("pll div", 8'h07, pdiv)
		`CHK("pll phase", 2'h2, pph)
		sleep_n <= 1'b1;
		tick(ccr_pkg::LOCK_CYC - 10);
		`CHK("early lock", 1'b0, locked)
		tick(20);
		`CHK("lock", 1'b1, locked)
		rd(ccr_pkg::OFF_ISTAT, 33'h3, "lock events");
		wr(ccr_pkg::OFF_ISTAT, 33'hf);
		wr(ccr_pkg::OFF_PLL, {18'h0, 1'h1, 4'h0, 8'h07, 2'h2});
		wr(ccr_pkg::OFF_PLL, {18'h0, 1'h1, 4'h0, 8'h09, 2'h2});
		wr(ccr_pkg::OFF_PLL, {18'h0, 1'h1, 4'hf, 8'h09, 2'h2});
		rd(ccr_pkg::OFF_ISTAT, 33'h0, "gated change");
		`CHK("new div", 8'h09, pdiv)
		wr(ccr_pkg::OFF_PLL, {18'h0, 1'h1, 4'hf, 8'h0b, 2'h2});
		wr(ccr_pkg::OFF_PLL, {18'h0, 1'h0, 4'h3, 8'h0b, 2'h2});
		rd(ccr_pkg::OFF_PLL, {18'h0, 1'h1, 4'h3, 8'h0b, 2'h2}, "refused pll");
		rd(ccr_pkg::OFF_ISTAT, 33'hc, "glitch refuse");
		`CHK("gates", 4'h3, gate)
		`CHK("irq masked", 1'b0, irq)
		wr(ccr_pkg::OFF_IMASK, 33'h4);
		tick(3);
		`CHK("irq", 1'b1, irq)
		wr(ccr_pkg::OFF_ISTAT, 33'h4);
		tick(3);
		`CHK("irq clear", 1'b0, irq)
		rd(ccr_pkg::OFF_ISTAT, 33'h8, "w1c");
		en <= 1'b0;
		wr(ccr_pkg::OFF_IMASK, 33'hf);
		en <= 1'b1;
		ce_in <= 1'b0;
		wr(ccr_pkg::OFF_IMASK, 33'hf);
		ce_in <= 1'b1;
		rd(ccr_pkg::OFF_IMASK, 33'h4, "port off");
		tick(1);
		nrst_in <= 1'b0;
		#1;
		`CHK("async rst", 1'b1, prst)
		`CHK("async gates", 4'h0, gate)
		tick(2);
		nrst_in <= 1'b1;
		tick(2);
		rd(ccr_pkg::OFF_PLL, 33'h3c04, "pll reload");
		rd(ccr_pkg::OFF_IMASK, 33'h0, "mask reload");
		tick(3);
		give_verdict();
	end
endmodule
`default_nettype wire
